/* sgtc_cfg.svh */
// Purpose: Offsets, reset values, field positions and codes of the test control bank
// Assumes: 16-bit management words, 5-bit register addresses
// Notes:   Included by bare name
`ifndef SGTC_CFG_SVH
`define SGTC_CFG_SVH

`define SGTC_ADDR_LOOPBACK    5'h16
`define SGTC_ADDR_GLOBAL      5'h18
`define SGTC_ADDR_RSVD_A      5'h19
`define SGTC_ADDR_STAT_A      5'h1A
`define SGTC_ADDR_STAT_B      5'h1B
`define SGTC_ADDR_STAT_C      5'h1C
`define SGTC_ADDR_SOFT_RESET  5'h1D
`define SGTC_ADDR_FACTORY     5'h1E
`define SGTC_ADDR_RESULT      5'h1F

`define SGTC_RST_LOOPBACK     16'h0000
`define SGTC_RST_GLOBAL       16'h100C
`define SGTC_RST_SOFT_RESET   16'h0000
`define SGTC_RST_FACTORY      16'h000B

`define SGTC_MASK_GLOBAL      16'hD30C
`define SGTC_MASK_FACTORY     16'hFF7F

`define SGTC_BIT_IDLE_MODE    15
`define SGTC_BIT_BUSY_PASS    14
`define SGTC_BIT_TOL_COMP     12
`define SGTC_BIT_CHECK_EN     9
`define SGTC_BIT_GEN_EN       8
`define SGTC_EMPH_HI          3
`define SGTC_EMPH_LO          2

`define SGTC_CHAR_K28_5       9'h1BC
`define SGTC_CHAR_D10_1       9'h02A
`define SGTC_CHAR_D15_2       9'h04F
`define SGTC_CHAR_D5_6        9'h0C5

`define SGTC_PRBS_SEED        7'h7F
`define SGTC_PREAMBLE_BITS    6'd32
`define SGTC_OP_READ          2'h2
`define SGTC_OP_WRITE         2'h1

`endif

/* sgtc_pkg.sv */
// Purpose: Types shared by the test control bank and its management port
// Assumes: Nothing beyond the configuration header
// Notes:   Constants live in sgtc_cfg.svh
package sgtc_pkg;

  typedef enum logic [1:0] {
    SGTC_EMPH_NONE = 2'b00,
    SGTC_EMPH_LOW  = 2'b01,
    SGTC_EMPH_MID  = 2'b10,
    SGTC_EMPH_HIGH = 2'b11
  } sgtc_emph_t;

  typedef enum logic [1:0] {
    SGTC_MD_PRE  = 2'b00,
    SGTC_MD_HDR  = 2'b01,
    SGTC_MD_TA   = 2'b10,
    SGTC_MD_DATA = 2'b11
  } sgtc_mdio_state_t;

endpackage

/* sgtc_mdio_slave.sv */
// Purpose: Clause 22 management frame slave, sampled in the mclk domain
// Assumes: mdc and mdioIn synchronous to mclk, mdc much slower than mclk
// Notes:   Output bits change right after each mdc rising edge
`timescale 1ns/1ps
`include "sgtc_cfg.svh"

module sgtc_mdio_slave #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  output logic             mdcRise,
  output logic [4:0]       regAddr,
  input  wire logic [15:0] rdData,
  output logic             wrStb,
  output logic [15:0]      wrData
);
  import sgtc_pkg::*;

  sgtc_mdio_state_t state;
  logic             mdcPrev;
  logic [5:0]       preCnt;
  logic [3:0]       bitCnt;
  logic [11:0]      hdr;
  logic             isRead;
  logic [15:0]      shift;
  logic [12:0]      full;

  assign mdcRise = mdc & ~mdcPrev;
  assign full    = {hdr, mdioIn};

  // Clock edge detect
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      mdcPrev <= 1'b0;
    else
      mdcPrev <= mdc;
  end

  // Frame sequencer
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state   <= SGTC_MD_PRE;
      preCnt  <= 6'd0;
      bitCnt  <= 4'd0;
      hdr     <= 12'h000;
      isRead  <= 1'b0;
      shift   <= 16'h0000;
      regAddr <= 5'h00;
      mdioOut <= 1'b0;
      mdioOe  <= 1'b0;
      wrStb   <= 1'b0;
      wrData  <= 16'h0000;
    end
    else
    begin
      wrStb <= 1'b0;
      if (mdcRise)
      begin
        case (state)
          SGTC_MD_PRE:
          begin
            if (mdioIn)
              preCnt <= (preCnt == `SGTC_PREAMBLE_BITS) ? preCnt : preCnt + 6'd1;
            else
            begin
              if (preCnt == `SGTC_PREAMBLE_BITS)
              begin
                state  <= SGTC_MD_HDR;
                bitCnt <= 4'd0;
              end
              preCnt <= 6'd0;
            end
          end
          SGTC_MD_HDR:
          begin
            hdr    <= full[11:0];
            bitCnt <= bitCnt + 4'd1;
            if (bitCnt == 4'd12)
            begin
              bitCnt <= 4'd0;
              if (full[12] && full[9:5] == PHY_ADDR &&
                  (full[11:10] == `SGTC_OP_READ || full[11:10] == `SGTC_OP_WRITE))
              begin
                state   <= SGTC_MD_TA;
                regAddr <= full[4:0];
                isRead  <= (full[11:10] == `SGTC_OP_READ);
              end
              else
                state <= SGTC_MD_PRE;
            end
          end
          SGTC_MD_TA:
          begin
            bitCnt <= bitCnt + 4'd1;
            if (bitCnt == 4'd0 && isRead)
            begin
              mdioOe  <= 1'b1;
              mdioOut <= 1'b0;
              shift   <= rdData;
            end
            if (bitCnt == 4'd1)
            begin
              state  <= SGTC_MD_DATA;
              bitCnt <= 4'd0;
              if (isRead)
              begin
                mdioOut <= shift[15];
                shift   <= {shift[14:0], 1'b0};
              end
            end
          end
          SGTC_MD_DATA:
          begin
            bitCnt <= bitCnt + 4'd1;
            if (isRead)
            begin
              mdioOut <= (bitCnt == 4'd15) ? 1'b0 : shift[15];
              shift   <= {shift[14:0], 1'b0};
              if (bitCnt == 4'd15)
                mdioOe <= 1'b0;
            end
            else
              shift <= {shift[14:0], mdioIn};
            if (bitCnt == 4'd15)
            begin
              state <= SGTC_MD_PRE;
              if (!isRead)
              begin
                wrStb  <= 1'b1;
                wrData <= {shift[14:0], mdioIn};
              end
            end
          end
          default:
            state <= SGTC_MD_PRE;
        endcase
      end
    end
  end

endmodule

/* sgtc_serdes_global_test_control.sv */
// Purpose: Global test control bank of an eight-channel serdes with its channel steering
// Assumes: Pins synchronous to mclk; characters carry K flag in bit 8
// Notes:   Channel A is channel 0 in every per-channel vector
// Behaviour
// - Comma plus data character marks idle
// - Transmit idle pair swaps D15.2 for D5.6
// - Idle mode is bit OR pin
// - Busy pattern passes as data when enabled
// - Busy passing is bit OR pin
// - Check enable runs all receive checkers
// - Generate enable drives patterns on channels
// - Two-bit emphasis level, reset high
// - Reserved bits and words read zero
// - Receive soft reset per channel bit
// - Transmit soft reset per channel bit
// - Soft reset bits clear next management cycle
// - Upper result byte shows receive pass
// - Lower result byte shows transmit pass
// - Near loop by pin or channel bit
// - Near loop tristates serial, returns parallel
// - Far loop sends received data back
// - Far loop tristates parallel receive outputs unless near loop is also active
// - Near loop bits ORed with pin
// - Far loop works on channel pairs
// - Pattern is seven-bit pseudo-random sequence
// - Pattern mode ignores parallel transmit data
`timescale 1ns/1ps
`include "sgtc_cfg.svh"

module sgtc_serdes_global_test_control #(
  parameter int         NCH      = 8,
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               mdc,
  input  wire logic               mdioIn,
  output logic                    mdioOut,
  output logic                    mdioOe,
  input  wire logic               gigabit_idle_pin,
  input  wire logic               busy_pattern_pin,
  input  wire logic               near_loop_pin,
  output logic                    gigabitIdleMode,
  output logic                    busyPatternPass,
  output logic                    toleranceCompEnable,
  output sgtc_pkg::sgtc_emph_t    globalEmphasisLevel,
  output logic [7:0]              factory_test_bits,
  output logic [NCH-1:0]          rxChannelReset,
  output logic [NCH-1:0]          txChannelReset,
  input  wire logic [NCH*9-1:0]   txChar,
  output logic [NCH*9-1:0]        txCharOut,
  input  wire logic [NCH*9-1:0]   rxChar,
  output logic [NCH-1:0]          rxIdleFlag,
  output logic [NCH-1:0]          rxIdleCompOk,
  input  wire logic [NCH*10-1:0]  txParallel,
  output logic [NCH*10-1:0]       serialTxWord,
  output logic [NCH-1:0]          serialOutOe,
  input  wire logic [NCH*10-1:0]  serialRxWord,
  output logic [NCH*10-1:0]       receive_parallel_bus,
  output logic [NCH-1:0]          receiveParallelOe
);
  import sgtc_pkg::*;

  logic        mdcRise;
  logic [4:0]  regAddr;
  logic [15:0] rdData;
  logic        wrStb;
  logic [15:0] wrData;

  logic [15:0] loopbackCtl;
  logic [15:0] globalCtl;
  logic [15:0] softReset;
  logic [15:0] factoryTest;
  logic [7:0]  rx_pattern_pass_flags;
  logic [7:0]  txPassFlags;

  logic        pattern_check_enable;
  logic        pattern_generate_enable;
  logic [7:0]  near_loop_bits;
  logic [7:0]  far_loop_enables;
  logic [7:0]  farLoopActive;
  logic [7:0]  nearLoopActive;

  sgtc_mdio_slave #(
    .PHY_ADDR (PHY_ADDR)
  ) u_mdio (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mdc     (mdc),
    .mdioIn  (mdioIn),
    .mdioOut (mdioOut),
    .mdioOe  (mdioOe),
    .mdcRise (mdcRise),
    .regAddr (regAddr),
    .rdData  (rdData),
    .wrStb   (wrStb),
    .wrData  (wrData)
  );

  // writable fields only, reserved bits stay zero
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      globalCtl <= `SGTC_RST_GLOBAL;
    else if (wrStb && regAddr == `SGTC_ADDR_GLOBAL)
      globalCtl <= wrData & `SGTC_MASK_GLOBAL;
  end

  // Loopback enables
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      loopbackCtl <= `SGTC_RST_LOOPBACK;
    else if (wrStb && regAddr == `SGTC_ADDR_LOOPBACK)
      loopbackCtl <= wrData;
  end

  // Factory test word, bit 7 held zero
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      factoryTest <= `SGTC_RST_FACTORY;
    else if (wrStb && regAddr == `SGTC_ADDR_FACTORY)
      factoryTest <= wrData & `SGTC_MASK_FACTORY;
  end

  // self clearing, a write wins over the clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      softReset <= `SGTC_RST_SOFT_RESET;
    else if (wrStb && regAddr == `SGTC_ADDR_SOFT_RESET)
      softReset <= softReset | wrData;
    else if (mdcRise)
      softReset <= 16'h0000;
  end

  // reserved and unlisted words read zero
  always_comb
  begin
    case (regAddr)
      `SGTC_ADDR_LOOPBACK:   rdData = loopbackCtl;
      `SGTC_ADDR_GLOBAL:     rdData = globalCtl;
      `SGTC_ADDR_SOFT_RESET: rdData = softReset;
      `SGTC_ADDR_FACTORY:    rdData = factoryTest;
      // receive pass flags in the upper byte
      `SGTC_ADDR_RESULT:     rdData = {rx_pattern_pass_flags, txPassFlags};
      default:               rdData = 16'h0000;
    endcase
  end

  // idle mode from bit or pin
  assign gigabitIdleMode         = globalCtl[`SGTC_BIT_IDLE_MODE] | gigabit_idle_pin;
  // busy passing from bit or pin
  assign busyPatternPass         = globalCtl[`SGTC_BIT_BUSY_PASS] | busy_pattern_pin;
  assign toleranceCompEnable     = globalCtl[`SGTC_BIT_TOL_COMP];
  assign pattern_check_enable    = globalCtl[`SGTC_BIT_CHECK_EN];
  assign pattern_generate_enable = globalCtl[`SGTC_BIT_GEN_EN];
  // emphasis field drives the level output
  assign globalEmphasisLevel     = sgtc_emph_t'(globalCtl[`SGTC_EMPH_HI:`SGTC_EMPH_LO]);
  assign factory_test_bits       = factoryTest[15:8];
  assign rxChannelReset          = softReset[15:8];
  assign txChannelReset          = softReset[7:0];
  assign near_loop_bits          = loopbackCtl[15:8];
  assign far_loop_enables        = loopbackCtl[7:0];

  // Advance the seven-bit sequence by one ten-bit word
  function automatic logic [16:0] prbsStep(input logic [6:0] seed);
    logic [6:0] s;
    logic [9:0] w;
    logic       nb;
    s = seed;
    w = 10'h000;
    for (int i = 0; i < 10; i++)
    begin
      nb        = s[6] ^ s[5];
      w[9 - i]  = nb;
      s         = {s[5:0], nb};
    end
    return {w, s};
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      logic [8:0] txC;
      logic [8:0] rxC;
      logic [8:0] txPrev;
      logic [8:0] rxPrev;
      logic [9:0] txW;
      logic [9:0] rxW;
      logic [6:0] genState;
      logic [9:0] genWord;
      logic [16:0] genNext;
      logic [16:0] chkNext;
      logic [9:0] expectWord;
      logic       expectValid;
      logic       rxPass;
      logic       txPass;
      logic       idleSeen;

      assign txC     = txChar[ch*9 +: 9];
      assign rxC     = rxChar[ch*9 +: 9];
      assign txW     = txParallel[ch*10 +: 10];
      assign rxW     = serialRxWord[ch*10 +: 10];
      assign genNext = prbsStep(genState);
      assign chkNext = prbsStep(rxW[6:0]);
      assign genWord = genNext[16:7];

      // Character history
      always_ff @(posedge mclk)
      begin
        if (!rst_n || rxChannelReset[ch])
          rxPrev <= 9'h000;
        else
          rxPrev <= rxC;
      end

      always_ff @(posedge mclk)
      begin
        if (!rst_n || txChannelReset[ch])
          txPrev <= 9'h000;
        else
          txPrev <= txC;
      end

      // comma then data character; busy pair stays data
      always_comb
      begin
        idleSeen = gigabitIdleMode && rxPrev == `SGTC_CHAR_K28_5 && !rxC[8] &&
                   !(busyPatternPass && rxC == `SGTC_CHAR_D10_1);
      end

      assign rxIdleFlag[ch]   = idleSeen;
      assign rxIdleCompOk[ch] = idleSeen & toleranceCompEnable;

      // disparity fix in transmit idle pair
      always_ff @(posedge mclk)
      begin
        if (!rst_n || txChannelReset[ch])
          txCharOut[ch*9 +: 9] <= 9'h000;
        else if (gigabitIdleMode && txPrev == `SGTC_CHAR_K28_5 && txC == `SGTC_CHAR_D15_2)
          txCharOut[ch*9 +: 9] <= `SGTC_CHAR_D5_6;
        else
          txCharOut[ch*9 +: 9] <= txC;
      end

      always_ff @(posedge mclk)
      begin
        if (!rst_n || txChannelReset[ch] || !pattern_generate_enable)
          genState <= `SGTC_PRBS_SEED;
        else
          genState <= genNext[6:0];
      end

      // receive checker predicts the next word
      always_ff @(posedge mclk)
      begin
        if (!rst_n || rxChannelReset[ch] || !pattern_check_enable)
        begin
          expectWord  <= 10'h000;
          expectValid <= 1'b0;
          rxPass      <= 1'b0;
        end
        else
        begin
          expectWord  <= chkNext[16:7];
          expectValid <= 1'b1;
          if (expectValid)
            rxPass <= (rxW == expectWord);
        end
      end

      // transmit side pass for factory use
      always_ff @(posedge mclk)
      begin
        if (!rst_n || txChannelReset[ch] || !pattern_generate_enable)
          txPass <= 1'b0;
        else
          txPass <= nearLoopActive[ch] || farLoopActive[ch] ||
                    serialTxWord[ch*10 +: 7] == genState;
      end

      assign rx_pattern_pass_flags[ch] = rxPass;
      assign txPassFlags[ch]           = txPass;

      // pin or bit; each bit ORed with pin
      assign nearLoopActive[ch] = near_loop_pin | near_loop_bits[ch];
      // both channels of a pair loop together
      assign farLoopActive[ch]  = far_loop_enables[ch] | far_loop_enables[ch ^ 1];

      // Channel steering
      always_ff @(posedge mclk)
      begin
        if (!rst_n || txChannelReset[ch])
        begin
          serialTxWord[ch*10 +: 10] <= 10'h000;
          serialOutOe[ch]           <= 1'b0;
        end
        else
        begin
          // serial outputs released during near loop
          serialOutOe[ch] <= !nearLoopActive[ch];
          if (farLoopActive[ch])
            serialTxWord[ch*10 +: 10] <= rxW;
          // generator drives the serializer; parallel data ignored
          else if (pattern_generate_enable)
            serialTxWord[ch*10 +: 10] <= genWord;
          else
            serialTxWord[ch*10 +: 10] <= txW;
        end
      end

      always_ff @(posedge mclk)
      begin
        if (!rst_n || rxChannelReset[ch])
        begin
          receive_parallel_bus[ch*10 +: 10] <= 10'h000;
          receiveParallelOe[ch]             <= 1'b0;
        end
        else
        begin
          // parallel receive outputs released in far loop unless near loop is also active
          receiveParallelOe[ch] <= !farLoopActive[ch] || nearLoopActive[ch];
          // parallel transmit data, or the generated word when generate is enabled, returns to receive side
          if (nearLoopActive[ch])
            receive_parallel_bus[ch*10 +: 10] <= pattern_generate_enable ? genWord : txW;
          else if (farLoopActive[ch])
            receive_parallel_bus[ch*10 +: 10] <= 10'h000;
          // pattern visible on the receive bus
          else if (pattern_generate_enable)
            receive_parallel_bus[ch*10 +: 10] <= genWord;
          else
            receive_parallel_bus[ch*10 +: 10] <= rxW;
        end
      end
    end
  endgenerate

endmodule

/* sgtc_gtc_monitor.sv */
// Purpose: Port checks of the test control bank
// Assumes: Bound into sgtc_serdes_global_test_control
// Notes:   One clock domain, reset active low
`timescale 1ns/1ps
`include "sgtc_cfg.svh"

module sgtc_gtc_monitor #(
  parameter int NCH = 8
) (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 mdc,
  input wire logic                 mdioOe,
  input wire logic                 gigabit_idle_pin,
  input wire logic                 busy_pattern_pin,
  input wire logic                 near_loop_pin,
  input wire logic                 gigabitIdleMode,
  input wire logic                 busyPatternPass,
  input wire logic                 toleranceCompEnable,
  input wire sgtc_pkg::sgtc_emph_t globalEmphasisLevel,
  input wire logic [NCH-1:0]       rxChannelReset,
  input wire logic [NCH-1:0]       txChannelReset,
  input wire logic [NCH*9-1:0]     txChar,
  input wire logic [NCH*9-1:0]     txCharOut,
  input wire logic [NCH*9-1:0]     rxChar,
  input wire logic [NCH-1:0]       rxIdleFlag,
  input wire logic [NCH-1:0]       rxIdleCompOk,
  input wire logic [NCH-1:0]       serialOutOe,
  input wire logic [NCH-1:0]       receiveParallelOe
);
  import sgtc_pkg::*;

  default clocking mcb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence mdc_edge;
    mdc && !$past(mdc);
  endsequence

  sequence tx_idle_pair;
    $past(rst_n) && $past(rst_n, 2) && $past(gigabitIdleMode)
      && !$past(txChannelReset[0]) && !$past(txChannelReset[0], 2)
      && $past(txChar[8:0], 2) == `SGTC_CHAR_K28_5 && $past(txChar[8:0]) == `SGTC_CHAR_D15_2;
  endsequence

  a_idle_pin_or: assert property (gigabit_idle_pin |-> gigabitIdleMode)
    else $error("idle mode ignores its pin");
  a_busy_pin_or: assert property (busy_pattern_pin |-> busyPatternPass)
    else $error("busy passing ignores its pin");
  a_comp_gate_ok: assert property (rxIdleCompOk == (rxIdleFlag & {NCH{toleranceCompEnable}}))
    else $error("compensation gate wrong");
  a_idle_needs_mode: assert property (rxIdleFlag != '0 |-> gigabitIdleMode)
    else $error("idle flagged outside idle mode");
  a_busy_not_idle: assert property (busyPatternPass && rxChar[8:0] == `SGTC_CHAR_D10_1 |-> !rxIdleFlag[0])
    else $error("busy pair flagged as idle");
  a_idle_tx_swap: assert property (tx_idle_pair |-> txCharOut[8:0] == `SGTC_CHAR_D5_6)
    else $error("idle pair not corrected");
  a_rst_values: assert property ($rose(rst_n) |-> globalEmphasisLevel == SGTC_EMPH_HIGH && toleranceCompEnable && !mdioOe)
    else $error("reset values wrong");
  a_soft_rst_clear: assert property (mdc_edge ##0 (rxChannelReset | txChannelReset) != '0 |-> ##[1:3] (rxChannelReset | txChannelReset) == '0)
    else $error("soft reset not cleared");
  a_near_serial_off: assert property ($past(near_loop_pin) |-> serialOutOe == '0)
    else $error("serial output driven in near loop");
  a_near_rx_on: assert property ($past(near_loop_pin) && $past(rst_n) && $past(rxChannelReset) == '0 |-> receiveParallelOe == '1)
    else $error("receive bus off in near loop");
endmodule

bind sgtc_serdes_global_test_control sgtc_gtc_monitor #(.NCH(NCH)) mon_u (
  .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdioOe(mdioOe),
  .gigabit_idle_pin(gigabit_idle_pin), .busy_pattern_pin(busy_pattern_pin),
  .near_loop_pin(near_loop_pin), .gigabitIdleMode(gigabitIdleMode),
  .busyPatternPass(busyPatternPass), .toleranceCompEnable(toleranceCompEnable),
  .globalEmphasisLevel(globalEmphasisLevel), .rxChannelReset(rxChannelReset),
  .txChannelReset(txChannelReset), .txChar(txChar), .txCharOut(txCharOut), .rxChar(rxChar),
  .rxIdleFlag(rxIdleFlag), .rxIdleCompOk(rxIdleCompOk), .serialOutOe(serialOutOe),
  .receiveParallelOe(receiveParallelOe)
);

/* sgtc_mdio_station.sv */
// Purpose: Management station sending clause 22 frames
// Assumes: Lines change at falling mclk edges; data line pulled up
// Notes:   mdc stands low between frames
`timescale 1ns/1ps
`include "sgtc_cfg.svh"

module sgtc_mdio_station #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic   mclk,
  output logic        mdc,
  output wire logic   mdioIn,
  input  wire logic   mdioOut,
  input  wire logic   mdioOe,
  output logic        rdDone,
  output logic [15:0] rdWord
);
  logic drive;
  logic bitVal;

  // Released line floats high unless the device drives it
  assign mdioIn = drive ? bitVal : (mdioOe ? mdioOut : 1'b1);

  initial
  begin
    mdc = 1'b0;
    drive = 1'b0;
    bitVal = 1'b1;
    rdDone = 1'b0;
    rdWord = 16'h0000;
  end

  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
    logic [63:0] frame;
    frame = {32'hFFFFFFFF, 2'b01, op, PHY_ADDR, ra, 2'b10, wd};
    for (int i = 0; i < 64; i++)
    begin
      @(negedge mclk);
      mdc = 1'b0;
      drive = (op == `SGTC_OP_WRITE) || (i < 46);
      bitVal = frame[63-i];
      repeat (2) @(negedge mclk);
      if (i >= 48)
        rdWord[63-i] = mdioIn;
      mdc = 1'b1;
      @(negedge mclk);
    end
    @(negedge mclk);
    mdc = 1'b0;
    drive = 1'b0;
    rdDone = (op == `SGTC_OP_READ);
    @(negedge mclk);
    rdDone = 1'b0;
  endtask
endmodule

/* sgtc_serdes_global_test_control_tb_top.sv */
// Purpose: Self-checking bench of the test control bank
// Assumes: Station model drives the management lines
// Notes:   Read words are checked from a queue of expected values
`timescale 1ns/1ps
`include "sgtc_cfg.svh"

module sgtc_serdes_global_test_control_tb_top;
  import sgtc_pkg::*;

  logic             mclk = 1'b0;
  logic             rst_n = 1'b0;
  logic             idlePin = 1'b0;
  logic             busyPin = 1'b0;
  logic             nearPin = 1'b0;
  logic [71:0]      txChar = '0;
  logic [71:0]      rxChar = '0;
  logic [79:0]      txParallel = '0;
  logic [79:0]      serialRxWord = '0;
  logic             mdc, mdioIn, mdioOut, mdioOe, rdDone;
  logic [15:0]      rdWord;
  logic             idleMode, busyPass, compEn;
  sgtc_emph_t       emph;
  logic [7:0]       rxRst, txRst, idleFlag, compOk, serOe, rxOe, ftBits;
  logic             echo = 1'b0;
  logic [71:0]      txCharOut;
  logic [79:0]      serTx, rxBus;
  logic [15:0]      expQ[$];
  logic [2:0]       k;
  logic [15:0]      v;
  int               failures = 0;
  int               num_checks = 0;

  initial
  begin
    forever #25 mclk = ~mclk;
  end

  sgtc_serdes_global_test_control dut_u (
    .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .gigabit_idle_pin(idlePin), .busy_pattern_pin(busyPin),
    .near_loop_pin(nearPin), .gigabitIdleMode(idleMode), .busyPatternPass(busyPass),
    .toleranceCompEnable(compEn), .globalEmphasisLevel(emph), .factory_test_bits(ftBits),
    .rxChannelReset(rxRst), .txChannelReset(txRst), .txChar(txChar),
    .txCharOut(txCharOut), .rxChar(rxChar), .rxIdleFlag(idleFlag), .rxIdleCompOk(compOk),
    .txParallel(txParallel), .serialTxWord(serTx), .serialOutOe(serOe),
    .serialRxWord(serialRxWord), .receive_parallel_bus(rxBus), .receiveParallelOe(rxOe)
  );

  sgtc_mdio_station stn_u (
    .mclk(mclk), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .rdDone(rdDone), .rdWord(rdWord)
  );

  task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    stn_u.xfer(`SGTC_OP_WRITE, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    expQ.push_back(e);
    stn_u.xfer(`SGTC_OP_READ, a, 16'h0000);
  endtask

  // Oldest expected word against each finished read
  always @(posedge rdDone)
  begin
    chk("rdata", 80'(expQ.pop_front()), 80'(rdWord));
  end

  // Far side returns the serial words to the deserializer
  always @(negedge mclk)
  begin
    if (echo)
      serialRxWord = serTx;
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    failures++;
    summarize();
  end

  initial
  begin
    void'($urandom(32'h923B));
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    rd(`SGTC_ADDR_GLOBAL, 16'h100C);
    rd(`SGTC_ADDR_LOOPBACK, 16'h0000);
    rd(`SGTC_ADDR_RESULT, 16'h0000);
    for (int a = 32'h19; a <= 32'h1F; a++)
    begin
      wr(5'(a), 16'hFFFF);
      rd(5'(a), (a == 32'h1E) ? 16'hFF7F : 16'h0000);
    end
    chk("factory_test_bits", 8'hFF, ftBits);
    wr(`SGTC_ADDR_GLOBAL, 16'h2CF3);
    rd(`SGTC_ADDR_GLOBAL, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      {busyPin, idlePin} = k[2:1];
      v = {k[0], k[1], 1'b0, k[2], 8'h00, k[1:0], 2'b00};
      wr(`SGTC_ADDR_GLOBAL, v);
      rd(`SGTC_ADDR_GLOBAL, v);
      chk("gigabitIdleMode", k[0] | k[1], idleMode);
      chk("busyPatternPass", k[1] | k[2], busyPass);
      chk("toleranceCompEnable", k[2], compEn);
      chk("globalEmphasisLevel", k[1:0], emph);
    end
    busyPin = 1'b0;
    idlePin = 1'b0;
    wr(`SGTC_ADDR_GLOBAL, 16'h9000);
    for (int b = 0; b < 2; b++)
    begin
      busyPin = 1'(b);
      rxChar = {8{`SGTC_CHAR_K28_5}};
      txChar = {8{`SGTC_CHAR_K28_5}};
      @(negedge mclk);
      rxChar = {8{`SGTC_CHAR_D10_1}};
      txChar = {8{`SGTC_CHAR_D15_2}};
      #1;
      chk("rxIdleFlag", (b != 0) ? 8'h00 : 8'hFF, idleFlag);
      chk("rxIdleCompOk", (b != 0) ? 8'h00 : 8'hFF, compOk);
      @(negedge mclk);
      chk("txCharOut", {8{`SGTC_CHAR_D5_6}}, txCharOut);
    end
    wr(`SGTC_ADDR_SOFT_RESET, 16'h8001);
    repeat (2) @(negedge mclk);
    chk("rxChannelReset", 8'h80, rxRst);
    chk("txChannelReset", 8'h01, txRst);
    rd(`SGTC_ADDR_SOFT_RESET, 16'h0000);
    chk("rxChannelReset", 8'h00, rxRst);
    txParallel = 80'({$urandom(), $urandom(), $urandom()});
    serialRxWord = 80'({$urandom(), $urandom(), $urandom()});
    nearPin = 1'b1;
    repeat (2) @(negedge mclk);
    chk("serialOutOe", 8'h00, serOe);
    chk("receive_parallel_bus", txParallel, rxBus);
    nearPin = 1'b0;
    wr(`SGTC_ADDR_LOOPBACK, 16'h0100);
    repeat (2) @(negedge mclk);
    chk("serialOutOe", 8'hFE, serOe);
    chk("receive_parallel_bus", {serialRxWord[79:10], txParallel[9:0]}, rxBus);
    wr(`SGTC_ADDR_LOOPBACK, 16'h0004);
    repeat (2) @(negedge mclk);
    chk("receiveParallelOe", 8'hF3, rxOe);
    chk("serialTxWord", {txParallel[79:40], serialRxWord[39:20], txParallel[19:0]}, serTx);
    wr(`SGTC_ADDR_LOOPBACK, 16'h0000);
    echo = 1'b1;
    wr(`SGTC_ADDR_GLOBAL, 16'h9300);
    repeat (3) @(negedge mclk);
    chk("receive_parallel_bus", serTx, rxBus);
    rd(`SGTC_ADDR_RESULT, 16'hFFFF);
    repeat (4) @(negedge mclk);
    summarize();
  end
endmodule
